/* src/ldp_params.svh */
`ifndef LDP_PARAMS_SVH
`define LDP_PARAMS_SVH

// system clock and internal dimming oscillator, in kHz
`define LDP_SYS_CLK_KHZ 50000
`define LDP_OSC_KHZ 20000
// 20 MHz tick from 50 MHz: add 2, wrap at 5
`define LDP_TICK_ADD 3'h2
`define LDP_TICK_MOD 3'h5

// external boost sync window, in kHz
`define LDP_SYNC_MIN_KHZ 100
`define LDP_SYNC_MAX_KHZ 2222
// shortest legal sync period rounds up, longest rounds down
`define LDP_SYNC_MIN_CYC ((`LDP_SYS_CLK_KHZ + `LDP_SYNC_MAX_KHZ - 1) / `LDP_SYNC_MAX_KHZ)
`define LDP_SYNC_MAX_CYC (`LDP_SYS_CLK_KHZ / `LDP_SYNC_MIN_KHZ)
`define LDP_SYNC_GOOD_EDGES 2'h2

// dimming period mask at the lowest frequency: 2^17 ticks, about 152 Hz
`define LDP_PERIOD_MASK_MAX 17'h1FFFF
// one third of 2^16, for 120 degree spacing
`define LDP_THIRD_Q16 17'h05556

// hybrid threshold 12.5 percent of full scale
`define LDP_HYB_THRESHOLD 16'h2000
`define LDP_HYB_LOW_SCALE 17'h02000
`define LDP_FULL_SCALE 17'h10000
`define LDP_FULL_DUTY 16'hFFFF

// spread spectrum decodes
`define LDP_DEV_00 8'h21
`define LDP_DEV_01 8'h2B
`define LDP_DEV_10 8'h35
`define LDP_DEV_11 8'h48
`define LDP_MOD_00 11'h0C8
`define LDP_MOD_01 11'h1F4
`define LDP_MOD_10 11'h320
`define LDP_MOD_11 11'h4B0

// i2c target addresses
`define LDP_ADDR_LOW 7'h3B
`define LDP_ADDR_HIGH 7'h3A

`endif

/* src/ldp_pkg.sv */
package ldp_pkg;

	typedef enum logic [1:0] {
		LDP_ST_CAPTURE = 2'b01,
		LDP_ST_RUN = 2'b10
	} ldp_state_t;

	typedef enum logic [1:0] {
		LDP_MODE_PHASE = 2'h0,
		LDP_MODE_HYBRID = 2'h1,
		LDP_MODE_CURRENT = 2'h2,
		LDP_MODE_DIRECT = 2'h3
	} ldp_mode_t;

	typedef struct packed {
		ldp_state_t st;
		logic [2:0] cfg;
		logic [2:0] fsel;
		logic [2:0] mode_code;
		logic [2:0] frac;
		logic [16:0] pcnt;
		logic [3:0] frame;
		logic pin_d;
		logic [16:0] hi_cnt;
		logic [16:0] per_cnt;
		logic div_busy;
		logic [4:0] div_cnt;
		logic [16:0] div_per;
		logic [17:0] div_rem;
		logic [15:0] div_q;
		logic [15:0] pin_brt;
		logic [15:0] brt_cur;
		logic [7:0] slope_cnt;
		logic [17:0] width;
		logic [16:0] ana;
		logic [3:0] led;
		logic [11:0] cur1;
		logic [11:0] cur2;
		logic [11:0] cur3;
		logic [11:0] cur4;
		logic sync_d;
		logic [9:0] sync_cnt;
		logic [1:0] sync_good;
	} ldp_state_s_t;

endpackage

/* src/ldp_phase_gate.sv */
`timescale 1ns/10ps
// one channel window: on while the phase-shifted count is below the width
module ldp_phase_gate (
	input wire logic [16:0] count,
	input wire logic [16:0] mask,
	input wire logic [16:0] offset,
	input wire logic [17:0] width,
	input wire logic active,
	output logic on
);
	logic [16:0] shifted;

	always_comb begin
		shifted = (count - offset) & mask;
		on = active && ({1'b0, shifted} < width);
	end
endmodule

/* src/ldp_dimming_top.sv */
`timescale 1ns/10ps
`include "ldp_params.svh"

module ldp_dimming_top (
	input wire logic sys_clk,
	input wire logic srst,
	input wire logic shutdown,
	input wire logic [2:0] string_config_resistor,
	input wire logic [2:0] dimming_frequency_resistor,
	input wire logic [2:0] dimming_mode_resistor,
	input wire logic pwm_in,
	input wire logic brightness_source_select,
	input wire logic [15:0] display_brightness_level,
	input wire logic [2:0] slope_select,
	input wire logic [2:0] dither_select,
	input wire logic hybrid_threshold_zero,
	input wire logic [11:0] string_current_code_one,
	input wire logic [11:0] string_current_code_two,
	input wire logic [11:0] string_current_code_three,
	input wire logic [11:0] string_current_code_four,
	input wire logic boost_sync_input,
	input wire logic [1:0] spread_deviation,
	input wire logic [1:0] spread_modulation_rate,
	output logic led_sink_output_one,
	output logic led_sink_output_two,
	output logic led_sink_output_three,
	output logic led_sink_output_four,
	output logic [11:0] string_current_level_one,
	output logic [11:0] string_current_level_two,
	output logic [11:0] string_current_level_three,
	output logic [11:0] string_current_level_four,
	output logic [15:0] brightness_level,
	output logic [1:0] dimming_mode,
	output logic [6:0] i2c_target_address,
	output logic config_latched,
	output logic boost_ext_sync,
	output logic spread_enable,
	output logic [7:0] spread_deviation_permille,
	output logic [10:0] spread_modulation_hz
);
	localparam logic [9:0] SYNC_MIN = 10'(`LDP_SYNC_MIN_CYC);
	localparam logic [9:0] SYNC_MAX = 10'(`LDP_SYNC_MAX_CYC);

	ldp_pkg::ldp_state_s_t s_reg;
	ldp_pkg::ldp_state_s_t s_next;

	logic tick;
	logic wrap;
	logic [16:0] mask;
	logic [1:0] ngroups_m1;
	logic [1:0] grp [4];
	logic [3:0] act;
	logic [16:0] offs [4];
	logic [3:0] gate_on;
	logic [15:0] target;
	logic [15:0] duty;
	logic [16:0] ana;
	logic [17:0] rem_sh;
	logic [3:0] dmask;
	logic [3:0] rev;
	logic [16:0] dropped;
	logic [17:0] w;

	// window length in ticks for a 16-bit duty at the strapped rate
	function automatic logic [17:0] scale_width(input logic [15:0] d, input logic [2:0] fs);
		scale_width = {1'b0, d, 1'b0} >> fs;
	endfunction

	// start of group k within a period of mask+1 ticks
	function automatic logic [16:0] phase_offset(input logic [1:0] k, input logic [1:0] nm1, input logic [16:0] m);
		logic [33:0] prod;
		prod = 34'({1'b0, m} + 18'h1) * 34'(`LDP_THIRD_Q16);
		unique case (nm1)
			2'h3: phase_offset = 17'((18'({1'b0, m} + 18'h1) >> 2) * k);
			2'h2: phase_offset = 17'(prod[32:16] * k);
			2'h1: phase_offset = 17'((18'({1'b0, m} + 18'h1) >> 1) * k);
			2'h0: phase_offset = 17'h0;
		endcase
	endfunction

	// code times analog scale, full scale is 2^16
	function automatic logic [11:0] scale_current(input logic [11:0] code, input logic [16:0] a);
		logic [28:0] p;
		p = 29'(code) * 29'(a);
		scale_current = p[27:16];
	endfunction

	for (genvar i = 0; i < 4; i++) begin : g_ch
		ldp_phase_gate u_gate (
			.count(s_reg.pcnt),
			.mask(mask),
			.offset(offs[i]),
			.width(s_reg.width),
			.active(act[i]),
			.on(gate_on[i])
		);
	end

	always_comb begin
		s_next = s_reg;
		tick = ({1'b0, s_reg.frac} + 4'(`LDP_TICK_ADD)) >= 4'(`LDP_TICK_MOD);
		s_next.frac = tick ? 3'(s_reg.frac + `LDP_TICK_ADD - `LDP_TICK_MOD) : 3'(s_reg.frac + `LDP_TICK_ADD);
		mask = `LDP_PERIOD_MASK_MAX >> s_reg.fsel;
		wrap = tick && (s_reg.pcnt == mask);

		// strap capture, held until shutdown
		unique case (s_reg.st)
			ldp_pkg::LDP_ST_CAPTURE: begin
				if (!shutdown) begin
					s_next.cfg = (string_config_resistor > 3'h4) ? 3'h0 : string_config_resistor;
					s_next.fsel = dimming_frequency_resistor;
					s_next.mode_code = dimming_mode_resistor;
					s_next.pcnt = 17'h0;
					s_next.st = ldp_pkg::LDP_ST_RUN;
				end
			end
			ldp_pkg::LDP_ST_RUN: begin
				if (shutdown) begin
					s_next.st = ldp_pkg::LDP_ST_CAPTURE;
				end
			end
		endcase

		// grouping and phase order per latched configuration
		act = 4'hF;
		grp[0] = 2'h0;
		grp[1] = 2'h1;
		grp[2] = 2'h2;
		grp[3] = 2'h3;
		ngroups_m1 = 2'h3;
		unique case (s_reg.cfg)
			3'h1: begin
				act = 4'h7;
				ngroups_m1 = 2'h2;
			end
			3'h2: begin
				act = 4'h3;
				ngroups_m1 = 2'h1;
			end
			3'h3: begin
				grp[1] = 2'h0;
				grp[2] = 2'h1;
				grp[3] = 2'h1;
				ngroups_m1 = 2'h1;
			end
			3'h4: begin
				grp[1] = 2'h0;
				grp[2] = 2'h0;
				grp[3] = 2'h0;
				ngroups_m1 = 2'h0;
			end
			default: begin
			end
		endcase
		if (s_reg.st != ldp_pkg::LDP_ST_RUN) begin
			act = 4'h0;
		end
		for (int i = 0; i < 4; i++) begin
			offs[i] = phase_offset(grp[i], ngroups_m1, mask);
		end

		// input duty measurement on the 20 MHz tick, period independent of output
		if (tick) begin
			s_next.pin_d = pwm_in;
			s_next.per_cnt = (s_reg.per_cnt == `LDP_PERIOD_MASK_MAX) ? s_reg.per_cnt : 17'(s_reg.per_cnt + 17'h1);
			if (pwm_in && s_reg.hi_cnt != `LDP_PERIOD_MASK_MAX) begin
				s_next.hi_cnt = 17'(s_reg.hi_cnt + 17'h1);
			end
			if (pwm_in && !s_reg.pin_d) begin
				s_next.per_cnt = 17'h1;
				s_next.hi_cnt = 17'h1;
				if (!s_reg.div_busy && s_reg.per_cnt != 17'h0) begin
					s_next.div_busy = 1'b1;
					s_next.div_cnt = 5'h10;
					s_next.div_per = s_reg.per_cnt;
					s_next.div_rem = {1'b0, s_reg.hi_cnt};
					s_next.div_q = 16'h0;
				end
			end else if (s_reg.per_cnt == `LDP_PERIOD_MASK_MAX) begin
				s_next.pin_brt = pwm_in ? `LDP_FULL_DUTY : 16'h0;
			end
		end
		// serial divide: high time over period
		rem_sh = {s_reg.div_rem[16:0], 1'b0};
		if (s_reg.div_busy) begin
			if ({1'b0, s_reg.div_rem[16:0]} >= {1'b0, s_reg.div_per}) begin
				s_next.pin_brt = `LDP_FULL_DUTY;
				s_next.div_busy = 1'b0;
			end else if (s_reg.div_cnt == 5'h0) begin
				s_next.pin_brt = s_reg.div_q;
				s_next.div_busy = 1'b0;
			end else begin
				s_next.div_cnt = 5'(s_reg.div_cnt - 5'h1);
				if (rem_sh >= {1'b0, s_reg.div_per}) begin
					s_next.div_rem = 18'(rem_sh - {1'b0, s_reg.div_per});
					s_next.div_q = {s_reg.div_q[14:0], 1'b1};
				end else begin
					s_next.div_rem = rem_sh;
					s_next.div_q = {s_reg.div_q[14:0], 1'b0};
				end
			end
		end

		// source select and slope stage
		target = brightness_source_select ? display_brightness_level : s_reg.pin_brt;
		if (slope_select == 3'h0) begin
			s_next.brt_cur = target;
		end else if (tick) begin
			s_next.slope_cnt = 8'(s_reg.slope_cnt + 8'h1);
			if (s_reg.slope_cnt >= (8'h1 << slope_select)) begin
				s_next.slope_cnt = 8'h0;
				if (s_reg.brt_cur < target) begin
					s_next.brt_cur = 16'(s_reg.brt_cur + 16'h1);
				end else if (s_reg.brt_cur > target) begin
					s_next.brt_cur = 16'(s_reg.brt_cur - 16'h1);
				end
			end
		end

		// split brightness between pulse width and analog scale
		duty = s_reg.brt_cur;
		ana = `LDP_FULL_SCALE;
		unique case (ldp_pkg::ldp_mode_t'(s_reg.mode_code[1:0]))
			ldp_pkg::LDP_MODE_PHASE: begin
			end
			ldp_pkg::LDP_MODE_HYBRID: begin
				if (!hybrid_threshold_zero && s_reg.brt_cur < `LDP_HYB_THRESHOLD) begin
					duty = {s_reg.brt_cur[12:0], 3'h0};
					ana = `LDP_HYB_LOW_SCALE;
				end else begin
					duty = `LDP_FULL_DUTY;
					ana = (s_reg.brt_cur == `LDP_FULL_DUTY) ? `LDP_FULL_SCALE : {1'b0, s_reg.brt_cur};
				end
			end
			ldp_pkg::LDP_MODE_CURRENT, ldp_pkg::LDP_MODE_DIRECT: begin
				duty = `LDP_FULL_DUTY;
				if (s_reg.mode_code[1:0] == 2'h2) begin
					ana = (s_reg.brt_cur == `LDP_FULL_DUTY) ? `LDP_FULL_SCALE : {1'b0, s_reg.brt_cur};
				end
			end
		endcase

		// dither: spread the truncated bits over up to 16 periods
		// low dither_select bits set, codes above 4 use all four
		dmask = 4'(~(5'h1F << dither_select));
		dmask = {dmask[0], dmask[1], dmask[2], dmask[3]};
		rev = {s_reg.frame[0], s_reg.frame[1], s_reg.frame[2], s_reg.frame[3]};
		dropped = 17'({duty, 1'b0} << (5'h11 - {2'h0, s_reg.fsel}));
		w = scale_width(duty, s_reg.fsel);
		if (duty == `LDP_FULL_DUTY) begin
			w = 18'({1'b0, mask} + 18'h1);
		end else if ((rev & dmask) < (dropped[16:13] & dmask)) begin
			w = 18'(w + 18'h1);
		end

		// free-running period counter from the oscillator tick
		if (tick && s_reg.st == ldp_pkg::LDP_ST_RUN) begin
			s_next.pcnt = wrap ? 17'h0 : 17'(s_reg.pcnt + 17'h1);
			if (wrap) begin
				s_next.frame = 4'(s_reg.frame + 4'h1);
				s_next.width = w;
				s_next.ana = ana;
			end
		end

		if (s_reg.mode_code[1:0] == 2'h3) begin
			s_next.led = act & {4{pwm_in}};
		end else begin
			s_next.led = gate_on;
		end
		s_next.cur1 = act[0] ? scale_current(string_current_code_one, s_reg.ana) : 12'h0;
		s_next.cur2 = act[1] ? scale_current(string_current_code_two, s_reg.ana) : 12'h0;
		s_next.cur3 = act[2] ? scale_current(string_current_code_three, s_reg.ana) : 12'h0;
		s_next.cur4 = act[3] ? scale_current(string_current_code_four, s_reg.ana) : 12'h0;

		// boost sync clock detection in system cycles
		s_next.sync_d = boost_sync_input;
		if (s_reg.sync_cnt <= SYNC_MAX) begin
			s_next.sync_cnt = 10'(s_reg.sync_cnt + 10'h1);
		end else begin
			s_next.sync_good = 2'h0;
		end
		if (boost_sync_input && !s_reg.sync_d) begin
			s_next.sync_cnt = 10'h1;
			if (s_reg.sync_cnt >= SYNC_MIN && s_reg.sync_cnt <= SYNC_MAX) begin
				if (s_reg.sync_good != `LDP_SYNC_GOOD_EDGES) begin
					s_next.sync_good = 2'(s_reg.sync_good + 2'h1);
				end
			end else begin
				s_next.sync_good = 2'h0;
			end
		end
	end

	always_ff @(posedge sys_clk) begin
		if (srst) begin
			s_reg <= '0;
			s_reg.st <= ldp_pkg::LDP_ST_CAPTURE;
			s_reg.ana <= `LDP_FULL_SCALE;
		end else begin
			s_reg <= s_next;
		end
	end

	assign led_sink_output_one = s_reg.led[0];
	assign led_sink_output_two = s_reg.led[1];
	assign led_sink_output_three = s_reg.led[2];
	assign led_sink_output_four = s_reg.led[3];
	assign string_current_level_one = s_reg.cur1;
	assign string_current_level_two = s_reg.cur2;
	assign string_current_level_three = s_reg.cur3;
	assign string_current_level_four = s_reg.cur4;
	assign brightness_level = s_reg.brt_cur;
	assign dimming_mode = s_reg.mode_code[1:0];
	assign i2c_target_address = s_reg.mode_code[2] ? `LDP_ADDR_HIGH : `LDP_ADDR_LOW;
	assign config_latched = (s_reg.st == ldp_pkg::LDP_ST_RUN);
	assign boost_ext_sync = (s_reg.sync_good == `LDP_SYNC_GOOD_EDGES);
	assign spread_enable = !boost_ext_sync && s_reg.sync_d;

	always_comb begin
		unique case (spread_deviation)
			2'h0: spread_deviation_permille = `LDP_DEV_00;
			2'h1: spread_deviation_permille = `LDP_DEV_01;
			2'h2: spread_deviation_permille = `LDP_DEV_10;
			2'h3: spread_deviation_permille = `LDP_DEV_11;
		endcase
		unique case (spread_modulation_rate)
			2'h0: spread_modulation_hz = `LDP_MOD_00;
			2'h1: spread_modulation_hz = `LDP_MOD_01;
			2'h2: spread_modulation_hz = `LDP_MOD_10;
			2'h3: spread_modulation_hz = `LDP_MOD_11;
		endcase
	end
endmodule

/* sim/ldp_host_model.sv */
`timescale 1ns/10ps
// host side: input pwm pin and boost sync pin
module ldp_host_model (
	input wire logic sys_clk,
	input wire logic [15:0] pwm_period,
	input wire logic [15:0] pwm_high,
	input wire logic [15:0] sync_period,
	input wire logic sync_level,
	output logic pwm_in,
	output logic boost_sync_input
);
	int pc = 0;
	int sc = 0;
	initial begin
		pwm_in = 1'b0;
		boost_sync_input = 1'b0;
	end
	// duty is high time over period, period zero gives a static level
	always @(posedge sys_clk) begin
		pc <= (pc + 1 >= pwm_period) ? 0 : pc + 1;
		pwm_in <= (pwm_period == 16'h0000) ? (pwm_high != 16'h0000) : (pc < pwm_high);
	end
	// square clock within the sync window, or a plain level when stopped
	always @(posedge sys_clk) begin
		sc <= (sc + 1 >= sync_period) ? 0 : sc + 1;
		boost_sync_input <= (sync_period == 16'h0000) ? sync_level : (sc < sync_period / 2);
	end
endmodule

/* sim/ldp_checker_assertions.sv */
`timescale 1ns/10ps
module ldp_checker (
	input wire logic sys_clk,
	input wire logic srst,
	input wire logic shutdown,
	input wire logic [2:0] dimming_mode_resistor,
	input wire logic pwm_in,
	input wire logic boost_sync_input,
	input wire logic [1:0] spread_deviation,
	input wire logic [1:0] spread_modulation_rate,
	input wire logic led_sink_output_one,
	input wire logic led_sink_output_two,
	input wire logic led_sink_output_three,
	input wire logic led_sink_output_four,
	input wire logic [1:0] dimming_mode,
	input wire logic [6:0] i2c_target_address,
	input wire logic config_latched,
	input wire logic boost_ext_sync,
	input wire logic spread_enable,
	input wire logic [7:0] spread_deviation_permille,
	input wire logic [10:0] spread_modulation_hz
);
	default clocking @(posedge sys_clk); endclocking
	default disable iff (srst);
	logic sync_d_reg;
	logic [9:0] gap_reg;
	// cycles since the last rising sync edge, saturating
	always_ff @(posedge sys_clk) begin
		sync_d_reg <= boost_sync_input;
		if (srst || (boost_sync_input && !sync_d_reg)) begin
			gap_reg <= 10'h000;
		end else if (gap_reg != 10'h3FF) begin
			gap_reg <= gap_reg + 10'h001;
		end
	end
	// outputs are registered behind the run state, dark from the third cycle
	sequence held_off;
		shutdown ##1 shutdown ##1 shutdown;
	endsequence
	spread_dev_a: assert property (spread_deviation_permille == (spread_deviation == 2'h0 ? 8'h21 :
		spread_deviation == 2'h1 ? 8'h2B : spread_deviation == 2'h2 ? 8'h35 : 8'h48)) else $error("deviation decode wrong");
	spread_rate_a: assert property (spread_modulation_hz == (spread_modulation_rate == 2'h0 ? 11'h0C8 :
		spread_modulation_rate == 2'h1 ? 11'h1F4 : spread_modulation_rate == 2'h2 ? 11'h320 : 11'h4B0))
		else $error("modulation decode wrong");
	sync_blocks_spread_a: assert property (boost_ext_sync && $past(boost_ext_sync) |-> !spread_enable)
		else $error("spread on with external sync");
	spread_pin_level_a: assert property (!boost_ext_sync && !$past(srst) |->
		spread_enable == $past(boost_sync_input)) else $error("spread enable not following sync pin");
	sync_gap_a: assert property (boost_ext_sync |-> gap_reg <= 10'h1F9)
		else $error("external sync kept without edges");
	latch_mode_a: assert property ($rose(config_latched) |-> dimming_mode == $past(dimming_mode_resistor[1:0]))
		else $error("latched mode wrong");
	latch_address_a: assert property ($rose(config_latched) |->
		i2c_target_address == ($past(dimming_mode_resistor[2]) ? 7'h3A : 7'h3B)) else $error("latched address wrong");
	straps_held_a: assert property (config_latched && $past(config_latched) |->
		$stable(dimming_mode) && $stable(i2c_target_address)) else $error("straps changed while latched");
	direct_follow_a: assert property (dimming_mode == 2'h3 && config_latched && $past(config_latched) && !shutdown
		&& !$past(shutdown) |-> led_sink_output_one == $past(pwm_in)) else $error("direct output not following pin");
	shutdown_dark_a: assert property (held_off |-> !led_sink_output_one && !led_sink_output_two
		&& !led_sink_output_three && !led_sink_output_four) else $error("outputs on in shutdown");
	shutdown_unlatch_a: assert property (held_off |-> !config_latched)
		else $error("configuration still latched in shutdown");
endmodule

/* sim/led_dimming_pwm_control_test.sv */
`timescale 1ns/10ps
module led_dimming_pwm_control_test;
	logic sys_clk, srst, shutdown, brightness_source_select, sync_level, pwm_in, boost_sync_input;
	logic hybrid_threshold_zero;
	logic [2:0] string_config_resistor, dimming_frequency_resistor, dimming_mode_resistor, slope_select;
	logic [2:0] dither_select;
	logic [15:0] display_brightness_level, pwm_period, pwm_high, sync_period, brightness_level;
	logic [11:0] string_current_code_one, string_current_level_one;
	logic [11:0] string_current_level_two, string_current_level_three, string_current_level_four;
	logic [1:0] spread_deviation, spread_modulation_rate, dimming_mode;
	logic led_sink_output_one, led_sink_output_two, led_sink_output_three, led_sink_output_four;
	logic config_latched, boost_ext_sync, spread_enable;
	logic [6:0] i2c_target_address;
	logic [7:0] spread_deviation_permille;
	logic [10:0] spread_modulation_hz;
	logic [7:0] dev_tab [4] = '{8'h21, 8'h2B, 8'h35, 8'h48};
	logic [10:0] mod_tab [4] = '{11'h0C8, 11'h1F4, 11'h320, 11'h4B0};
	int num_errors = 0;
	int checked = 0;
	int cyc = 0;
	int seed = 8530;
	int per, hi, off, e, h, c;
	ldp_dimming_top dut_u (.sys_clk, .srst, .shutdown, .string_config_resistor, .dimming_frequency_resistor,
		.dimming_mode_resistor, .pwm_in, .brightness_source_select, .display_brightness_level, .slope_select,
		.dither_select, .hybrid_threshold_zero, .string_current_code_one,
		.string_current_code_two(12'hFFF), .string_current_code_three(12'hFFF), .string_current_code_four(12'hFFF),
		.boost_sync_input, .spread_deviation, .spread_modulation_rate, .led_sink_output_one, .led_sink_output_two,
		.led_sink_output_three, .led_sink_output_four, .string_current_level_one, .string_current_level_two,
		.string_current_level_three, .string_current_level_four, .brightness_level, .dimming_mode,
		.i2c_target_address, .config_latched, .boost_ext_sync, .spread_enable, .spread_deviation_permille,
		.spread_modulation_hz);
	ldp_host_model host_u (.sys_clk, .pwm_period, .pwm_high, .sync_period, .sync_level, .pwm_in, .boost_sync_input);
	initial begin
		sys_clk = 1'b0;
		forever #10 sys_clk = ~sys_clk;
	end
	always @(posedge sys_clk) begin
		cyc <= cyc + 1;
		if (cyc == 99000) begin
			num_errors = num_errors + 1;
			complete_run();
		end
	end
	task complete_run();
		if (num_errors == 0 && checked > 0) $display("No errors found");
		else $display("Errors were found");
		$finish;
	endtask
	// waits n edges, then settles on the falling edge
	task tick(input int n);
		repeat (n) @(posedge sys_clk);
		@(negedge sys_clk);
	endtask
	task check(input logic [31:0] got, input logic [31:0] exp, input int tol);
		logic ok;
		ok = (tol == 0) ? (got === exp) : ((got + tol >= exp) && (got <= exp + tol));
		checked = checked + 1;
		if (ok !== 1'b1) begin
			num_errors = num_errors + 1;
			$display("BAD %0t got %0h exp %0h", $time, got, exp);
		end
	endtask
	task relatch(input logic [2:0] cf, input logic [2:0] fr, input logic [2:0] md);
		@(posedge sys_clk) shutdown <= 1'b1;
		tick(4);
		@(posedge sys_clk);
		string_config_resistor <= cf;
		dimming_frequency_resistor <= fr;
		dimming_mode_resistor <= md;
		tick(4);
		@(posedge sys_clk) shutdown <= 1'b0;
		for (int i = 0; i < 20 && config_latched !== 1'b1; i++) tick(1);
		tick(2);
		check(i2c_target_address, md[2] ? 7'h3A : 7'h3B, 0);
		check(dimming_mode, md[1:0], 0);
	endtask
	// one period of channel one, from rise to rise
	task automatic measure(output int pr, output int hw, output int of);
		logic p1, p2;
		p1 = 1'b1;
		for (int i = 0; i < 30000; i++) begin
			@(negedge sys_clk);
			if (p1 === 1'b0 && led_sink_output_one === 1'b1) break;
			p1 = led_sink_output_one;
		end
		p1 = 1'b1;
		p2 = led_sink_output_two;
		hw = 0;
		of = -1;
		for (pr = 1; pr < 30000; pr++) begin
			@(negedge sys_clk);
			if (led_sink_output_one === 1'b1) hw++;
			if (of < 0 && p2 === 1'b0 && led_sink_output_two === 1'b1) of = pr;
			if (p1 === 1'b0 && led_sink_output_one === 1'b1) break;
			p1 = led_sink_output_one;
			p2 = led_sink_output_two;
		end
	endtask
	function automatic int exp_level(input int m, input int b, input int cd);
		if (m == 1 && b < 'h2000) return cd / 8;
		return cd * b / 65536;
	endfunction
	initial begin
		srst = 1'b1;
		shutdown = 1'b0;
		string_config_resistor = 3'h0;
		dimming_frequency_resistor = 3'h7;
		dimming_mode_resistor = 3'h0;
		brightness_source_select = 1'b1;
		display_brightness_level = 16'h8000;
		slope_select = 3'h0;
		dither_select = 3'h0;
		hybrid_threshold_zero = 1'b0;
		string_current_code_one = 12'hFFF;
		spread_deviation = 2'h2;
		spread_modulation_rate = 2'h0;
		pwm_period = 16'h03E8;
		pwm_high = 16'h00FA;
		sync_period = 16'h0000;
		sync_level = 1'b0;
		tick(20);
		@(posedge sys_clk) srst <= 1'b0;
		for (int i = 0; i < 3; i++) begin
			relatch(i[2:0], 3'h5 + i[2:0], (i == 1) ? 3'h4 : 3'h0);
			measure(per, hi, off);
			e = (1 << (12 - i)) * 5 / 2;
			check(per, e, 4);
			check(hi, e / 2, 4);
			check(off, e / (4 - i), 4);
			check(string_current_level_one, 12'hFFF, 0);
			check(string_current_level_two, 12'hFFF, 0);
			check(string_current_level_three, (i < 2) ? 12'hFFF : 12'h0, 0);
			check(string_current_level_four, (i == 0) ? 12'hFFF : 12'h0, 0);
		end
		// one dither bit: every second pulse one tick longer, two periods counted from a rise
		@(posedge sys_clk);
		dither_select <= 3'h1;
		display_brightness_level <= 16'h8020;
		measure(per, hi, off);
		h = 0;
		repeat (5120) begin
			if (led_sink_output_one === 1'b1) h++;
			@(negedge sys_clk);
		end
		check(h, 2562, 1);
		@(posedge sys_clk);
		dither_select <= 3'h0;
		display_brightness_level <= 16'h8000;
		dimming_mode_resistor <= 3'h7;
		string_config_resistor <= 3'h4;
		tick(10);
		check(dimming_mode, 2'h0, 0);
		check(i2c_target_address, 7'h3B, 0);
		@(posedge sys_clk);
		slope_select <= 3'h1;
		display_brightness_level <= 16'h9000;
		tick(20);
		check(brightness_level, 16'h8000 + 20 * 2 / 5 / 3, 1);
		@(posedge sys_clk);
		slope_select <= 3'h0;
		brightness_source_select <= 1'b0;
		repeat (3) begin
			h = 100 + {$random(seed)} % 800;
			@(posedge sys_clk) pwm_high <= h[15:0];
			tick(4000);
			check(brightness_level, h * 65536 / 1000, 16'h0180);
		end
		@(posedge sys_clk) brightness_source_select <= 1'b1;
		// last pass: hybrid with zero threshold acts as pure current dimming
		for (int i = 0; i < 4; i++) begin
			c = 2048 + {$random(seed)} % 2048;
			e = (i >= 2) ? 'h1000 : 'h8000;
			@(posedge sys_clk);
			string_current_code_one <= c[11:0];
			display_brightness_level <= e[15:0];
			hybrid_threshold_zero <= (i == 3);
			relatch(3'h0, 3'h7, (i == 0) ? 3'h2 : 3'h1);
			tick(3000);
			check(string_current_level_one, exp_level((i == 0 || i == 3) ? 2 : 1, e, c), 1);
		end
		relatch(3'h0, 3'h7, 3'h3);
		tick(2000);
		@(posedge sys_clk) sync_period <= 16'h0064;
		tick(600);
		check(boost_ext_sync, 1'b1, 0);
		check(spread_enable, 1'b0, 0);
		@(posedge sys_clk);
		sync_period <= 16'h0000;
		sync_level <= 1'b1;
		tick(800);
		check(boost_ext_sync, 1'b0, 0);
		check(spread_enable, 1'b1, 0);
		for (int i = 0; i < 4; i++) begin
			@(posedge sys_clk);
			spread_deviation <= i[1:0];
			spread_modulation_rate <= i[1:0];
			tick(2);
			check(spread_deviation_permille, dev_tab[i], 0);
			check(spread_modulation_hz, mod_tab[i], 0);
		end
		complete_run();
	end
endmodule
bind ldp_dimming_top ldp_checker chk_u (.sys_clk, .srst, .shutdown, .dimming_mode_resistor, .pwm_in,
	.boost_sync_input, .spread_deviation, .spread_modulation_rate, .led_sink_output_one, .led_sink_output_two,
	.led_sink_output_three, .led_sink_output_four, .dimming_mode, .i2c_target_address, .config_latched,
	.boost_ext_sync, .spread_enable, .spread_deviation_permille, .spread_modulation_hz);
